// ==== rtl/umb_pkg.sv ====
// Register map, field positions and reset values of the modem/baud block
package umb_pkg;

  // Register byte addresses
  localparam logic [31:0] UMB_OFF_DATA    = 32'h1d00_0300;
  localparam logic [31:0] UMB_OFF_IER     = 32'h1d00_0304;
  localparam logic [31:0] UMB_OFF_IID     = 32'h1d00_0308;
  localparam logic [31:0] UMB_OFF_LCR     = 32'h1d00_030c;
  localparam logic [31:0] UMB_OFF_MCR     = 32'h1d00_0310;
  localparam logic [31:0] UMB_OFF_MSR     = 32'h1d00_0318;
  localparam logic [31:0] UMB_OFF_SCRATCH = 32'h1d00_031c;
  localparam logic [31:0] UMB_OFF_PSC     = 32'h1d00_0320;

  // Field positions
  localparam int UMB_LCR_DIVISOR_LATCH_SELECT_BIT  = 7;
  localparam int UMB_IER_MODEM_BIT = 3;
  localparam int UMB_MCR_DTR_BIT   = 0;
  localparam int UMB_MCR_LOOP_BIT  = 4;
  localparam int UMB_MSR_DDSR_BIT  = 1;
  localparam int UMB_MSR_TERI_BIT  = 2;
  localparam int UMB_MSR_DDCD_BIT  = 3;
  localparam int UMB_MSR_LVL_LSB   = 5;
  localparam int UMB_PSC_W         = 4;
  localparam int UMB_DIV_W         = 16;

  // Reset values
  localparam logic [7:0]  UMB_RST_BYTE = 8'h00;
  localparam logic [3:0]  UMB_RST_PSC  = 4'h0;
  localparam logic [15:0] UMB_RST_DIV  = 16'h0000;

  // Interrupt identification codes
  localparam logic [2:0] UMB_IID_MODEM = 3'h0;
  localparam logic [2:0] UMB_IID_NONE  = 3'h1;

  // AXI responses
  localparam logic [1:0] UMB_RESP_OKAY   = 2'h0;
  localparam logic [1:0] UMB_RESP_SLVERR = 2'h2;

  // Register selects
  typedef enum {
    UMB_SEL_DATA,
    UMB_SEL_IER,
    UMB_SEL_IID,
    UMB_SEL_LCR,
    UMB_SEL_MCR,
    UMB_SEL_MSR,
    UMB_SEL_SCRATCH,
    UMB_SEL_PSC,
    UMB_SEL_NONE
  } umb_sel_e;

endpackage : umb_pkg

// ==== rtl/umb_baud_gen.sv ====
// Prescaler and 16-bit baud divisor producing one-cycle enable ticks
`timescale 1ns/1ps
`default_nettype none
module umb_baud_gen
  import umb_pkg::*;
#(
  parameter int PSC_W = UMB_PSC_W,
  parameter int DIV_W = UMB_DIV_W
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [PSC_W-1:0] prescale,
  input  wire logic [DIV_W-1:0] divisor,
  input  wire logic             reload,
  output var  logic             prescaled_tick,
  output var  logic             baud_tick
);

  logic [PSC_W-1:0] psc_cnt;
  logic [DIV_W-1:0] div_cnt;

  ////////////////////////////////////////////////////////////////////////
  // Prescaler: field value n gives one tick every n+1 clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      psc_cnt        <= '0;
      prescaled_tick <= 1'b0;
    end else if (psc_cnt >= prescale) begin
      psc_cnt        <= '0;
      prescaled_tick <= 1'b1;
    end else begin
      psc_cnt        <= psc_cnt + 1'b1;
      prescaled_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Divisor counter on prescaled ticks; divisor zero holds it idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt   <= '0;
      baud_tick <= 1'b0;
    end else if (reload) begin
      div_cnt   <= '0;
      baud_tick <= 1'b0;
    end else if (prescaled_tick && divisor != '0) begin
      if (div_cnt + 1'b1 >= divisor) begin
        div_cnt   <= '0;
        baud_tick <= 1'b1;
      end else begin
        div_cnt   <= div_cnt + 1'b1;
        baud_tick <= 1'b0;
      end
    end else begin
      baud_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  psc_spacing_a: assert property (
    prescaled_tick && prescale != '0 && $stable(prescale) |=> !prescaled_tick)
    else $error("prescaled tick repeated too soon");

  // Divisor one at ratio one ticks on every clock; that case is checked below
  baud_single_a: assert property (
    baud_tick && divisor != 16'h0001 |=> !baud_tick)
    else $error("baud tick longer than one cycle");

  baud_div1_a: assert property (
    prescaled_tick && divisor == 16'h0001 && !reload && $stable(divisor)
    |=> baud_tick)
    else $error("divisor one did not tick on every prescaled tick");

endmodule : umb_baud_gen
`default_nettype wire

// ==== rtl/umb_uart_modem.sv ====
// Modem status, scratch and baud divisor registers behind AXI4-Lite
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Delta data-set-ready flag, status bit 1, sets on any DSR level change.
// - Ring trailing-edge flag, status bit 2, sets only on RI low to high.
// - Delta carrier-detect flag, status bit 3, sets on any DCD change.
// - Reading modem status clears the three change flags.
// - Status bits 5, 6, 7 show live DSR, RI, DCD levels.
// - Scratch byte is read/write storage with no effect on the UART.
// - Divisor low byte supplies divisor bits 7 to 0.
// - Divisor high byte supplies divisor bits 15 to 8.
// - Baud generator divides the prescaled clock by divisor 1 to 65535.
// - Prescaled clock is system clock divided by 1 to 16 via 4-bit field.
// - Divisor low shares the data location, reached only with select set.
// - Line control bit 7 redirects shared locations to divisor bytes.
// - Any set change flag raises interrupt code 000, cleared by status read.
// - Modem interrupt only raised while enable bit 3 is set.
// - Loopback disconnects external DSR, DCD and RI inputs.
module umb_uart_modem
  import umb_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              dsr_pin,
  input  wire logic              ri_pin,
  input  wire logic              dcd_pin,
  output var  logic              dtr_n_pin,
  output var  logic              modem_irq,
  output var  logic              serial_prescaled_clock,
  output var  logic              baud_tick
);

  ////////////////////////////////////////////////////////////////////////
  // Address decode shared by the read and write paths
  function automatic umb_sel_e reg_decode(input logic [ADDR_W-1:0] addr);
    logic [31:0] a;
    a = 32'(addr);
    case (a)
      UMB_OFF_DATA:    reg_decode = UMB_SEL_DATA;
      UMB_OFF_IER:     reg_decode = UMB_SEL_IER;
      UMB_OFF_IID:     reg_decode = UMB_SEL_IID;
      UMB_OFF_LCR:     reg_decode = UMB_SEL_LCR;
      UMB_OFF_MCR:     reg_decode = UMB_SEL_MCR;
      UMB_OFF_MSR:     reg_decode = UMB_SEL_MSR;
      UMB_OFF_SCRATCH: reg_decode = UMB_SEL_SCRATCH;
      UMB_OFF_PSC:     reg_decode = UMB_SEL_PSC;
      default:         reg_decode = UMB_SEL_NONE;
    endcase
  endfunction : reg_decode

  // Software-visible state
  logic [7:0]           line_ctrl;
  logic [3:0]           irq_enable;
  logic                 dtr_bit;
  logic                 loopback;
  logic [7:0]           scratch_byte;
  logic [7:0]           baud_divisor_low;
  logic [7:0]           baud_divisor_high;
  logic [UMB_PSC_W-1:0] uart_clock_prescaler;
  logic                 delta_data_set_ready_flag;
  logic                 ring_trailing_edge_flag;
  logic                 delta_carrier_detect_flag;

  // Bus slave state
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0]        w_byte_q;
  logic              w_lane0_q;
  umb_sel_e          wr_sel;
  umb_sel_e          rd_sel;
  logic              do_write;
  logic              wr_en;
  logic              rd_take;
  logic              msr_read;
  logic              wr_ok;
  logic              div_reload;
  logic              divisor_latch_select;

  // Modem input path
  logic [2:0] mdm_sync1;
  logic [2:0] mdm_sync2;
  logic [2:0] mdm_now;
  logic [2:0] mdm_prev;
  logic       any_change;
  logic [2:0] interrupt_identification_code;
  logic [7:0] msr_value;
  logic [7:0] next_rdata;

  assign divisor_latch_select = line_ctrl[UMB_LCR_DIVISOR_LATCH_SELECT_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Write channel handshake: address and data are taken in any order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign wr_sel        = reg_decode(aw_addr_q);
  assign wr_en         = do_write && w_lane0_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held   <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held   <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held    <= 1'b0;
      w_byte_q  <= UMB_RST_BYTE;
      w_lane0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held    <= 1'b1;
      w_byte_q  <= s_axi_wdata[7:0];
      w_lane0_q <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held    <= 1'b0;
    end
  end

  // Writable locations; others answer with an error
  always_comb begin
    case (wr_sel)
      UMB_SEL_DATA, UMB_SEL_IER, UMB_SEL_LCR, UMB_SEL_MCR,
      UMB_SEL_SCRATCH, UMB_SEL_PSC: wr_ok = 1'b1;
      default:                      wr_ok = 1'b0;
    endcase
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= UMB_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? UMB_RESP_OKAY : UMB_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_ctrl  <= UMB_RST_BYTE;
      irq_enable <= '0;
      dtr_bit    <= 1'b0;
      loopback   <= 1'b0;
    end else if (wr_en) begin
      if (wr_sel == UMB_SEL_LCR) begin
        line_ctrl <= w_byte_q;
      end
      if (wr_sel == UMB_SEL_IER && !divisor_latch_select) begin
        irq_enable <= w_byte_q[3:0];
      end
      if (wr_sel == UMB_SEL_MCR) begin
        dtr_bit  <= w_byte_q[UMB_MCR_DTR_BIT];
        loopback <= w_byte_q[UMB_MCR_LOOP_BIT];
      end
    end
  end

  // Scratch byte: storage only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scratch_byte <= UMB_RST_BYTE;
    end else if (wr_en && wr_sel == UMB_SEL_SCRATCH) begin
      scratch_byte <= w_byte_q;
    end
  end

  // Divisor bytes, reached at the shared locations only with select set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_divisor_low  <= UMB_RST_DIV[7:0];
      baud_divisor_high <= UMB_RST_DIV[15:8];
    end else if (wr_en && divisor_latch_select) begin
      if (wr_sel == UMB_SEL_DATA) begin
        baud_divisor_low <= w_byte_q;
      end
      if (wr_sel == UMB_SEL_IER) begin
        baud_divisor_high <= w_byte_q;
      end
    end
  end

  // Prescaler field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uart_clock_prescaler <= UMB_RST_PSC;
    end else if (wr_en && wr_sel == UMB_SEL_PSC) begin
      uart_clock_prescaler <= w_byte_q[UMB_PSC_W-1:0];
    end
  end

  assign div_reload = wr_en && divisor_latch_select &&
                      (wr_sel == UMB_SEL_DATA || wr_sel == UMB_SEL_IER);

  ////////////////////////////////////////////////////////////////////////
  // Baud generator
  umb_baud_gen #(
    .PSC_W (UMB_PSC_W),
    .DIV_W (UMB_DIV_W)
  ) u_baud (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .prescale       (uart_clock_prescaler),
    .divisor        ({baud_divisor_high, baud_divisor_low}),
    .reload         (div_reload),
    .prescaled_tick (serial_prescaled_clock),
    .baud_tick      (baud_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Modem inputs: two-flop synchronisers, order {dcd, ri, dsr}
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mdm_sync1 <= '0;
      mdm_sync2 <= '0;
    end else begin
      mdm_sync1 <= {dcd_pin, ri_pin, dsr_pin};
      mdm_sync2 <= mdm_sync1;
    end
  end

  // Loopback replaces the pins: DSR follows the DTR bit, RI and DCD low
  assign mdm_now = loopback ? {2'b00, dtr_bit} : mdm_sync2;

  // Previous level for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mdm_prev <= '0;
    end else begin
      mdm_prev <= mdm_now;
    end
  end

  assign rd_take  = s_axi_arvalid && s_axi_arready;
  assign rd_sel   = reg_decode(s_axi_araddr);
  assign msr_read = rd_take && rd_sel == UMB_SEL_MSR;

  // Change flags: a new event wins over a clearing read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      delta_data_set_ready_flag <= 1'b0;
      ring_trailing_edge_flag   <= 1'b0;
      delta_carrier_detect_flag <= 1'b0;
    end else begin
      delta_data_set_ready_flag <= (delta_data_set_ready_flag && !msr_read)
                                   || (mdm_now[0] ^ mdm_prev[0]);
      ring_trailing_edge_flag   <= (ring_trailing_edge_flag && !msr_read)
                                   || (mdm_now[1] && !mdm_prev[1]);
      delta_carrier_detect_flag <= (delta_carrier_detect_flag && !msr_read)
                                   || (mdm_now[2] ^ mdm_prev[2]);
    end
  end

  assign any_change = delta_data_set_ready_flag || ring_trailing_edge_flag ||
                      delta_carrier_detect_flag;

  // Modem interrupt and its identification code
  assign modem_irq = any_change && irq_enable[UMB_IER_MODEM_BIT];
  assign interrupt_identification_code =
    modem_irq ? UMB_IID_MODEM : UMB_IID_NONE;

  // DTR pin is low while the bit is set, inactive high in loopback
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dtr_n_pin <= 1'b1;
    end else begin
      dtr_n_pin <= !(dtr_bit && !loopback);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel: data registered one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;
  assign msr_value = {mdm_now, 1'b0, delta_carrier_detect_flag,
                      ring_trailing_edge_flag, delta_data_set_ready_flag,
                      1'b0};

  always_comb begin
    case (rd_sel)
      UMB_SEL_DATA:
        next_rdata = divisor_latch_select ? baud_divisor_low : 8'h00;
      UMB_SEL_IER:
        next_rdata = divisor_latch_select ? baud_divisor_high
                                          : {4'h0, irq_enable};
      UMB_SEL_IID:     next_rdata = {5'h00, interrupt_identification_code};
      UMB_SEL_LCR:     next_rdata = line_ctrl;
      UMB_SEL_MCR:     next_rdata = {3'h0, loopback, 3'h0, dtr_bit};
      UMB_SEL_MSR:     next_rdata = msr_value;
      UMB_SEL_SCRATCH: next_rdata = scratch_byte;
      UMB_SEL_PSC:     next_rdata = {4'h0, uart_clock_prescaler};
      default:         next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= UMB_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, next_rdata};
      s_axi_rresp  <= (rd_sel == UMB_SEL_NONE) ? UMB_RESP_SLVERR
                                                : UMB_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence msr_read_s;
    msr_read ##1 s_axi_rvalid;
  endsequence

  dsr_delta_a: assert property (
    mdm_now[0] != mdm_prev[0] |=> delta_data_set_ready_flag)
    else $error("DSR change did not set its flag");

  ri_edge_a: assert property (
    !ring_trailing_edge_flag && !(mdm_now[1] && !mdm_prev[1])
    |=> !ring_trailing_edge_flag)
    else $error("ring flag set without rising RI");

  dcd_delta_a: assert property (
    mdm_now[2] != mdm_prev[2] |=> delta_carrier_detect_flag)
    else $error("DCD change did not set its flag");

  msr_clear_a: assert property (
    msr_read && mdm_now == mdm_prev |=> !any_change)
    else $error("status read left a change flag set");

  msr_level_a: assert property (
    msr_read_s |-> s_axi_rdata[7:5] == $past(mdm_now))
    else $error("status levels wrong in read data");

  scratch_keep_a: assert property (
    !(wr_en && wr_sel == UMB_SEL_SCRATCH) |=> $stable(scratch_byte))
    else $error("scratch byte changed without a write");

  div_low_a: assert property (
    wr_en && divisor_latch_select && wr_sel == UMB_SEL_DATA
    |=> baud_divisor_low == $past(w_byte_q))
    else $error("divisor low byte not written");

  div_gate_a: assert property (
    wr_en && !divisor_latch_select |=> $stable(baud_divisor_low) &&
    $stable(baud_divisor_high))
    else $error("divisor written with select clear");

  irq_raise_a: assert property (
    irq_enable[UMB_IER_MODEM_BIT] && !msr_read && !wr_en &&
    $stable(irq_enable) && mdm_now[0] != mdm_prev[0]
    |=> modem_irq && interrupt_identification_code == UMB_IID_MODEM)
    else $error("modem change did not raise interrupt code");

  irq_mask_a: assert property (
    !irq_enable[UMB_IER_MODEM_BIT] |-> !modem_irq ##1
    (irq_enable[UMB_IER_MODEM_BIT] || !modem_irq))
    else $error("modem interrupt raised while disabled");

  loop_iso_a: assert property (
    loopback ##1 loopback |-> !ring_trailing_edge_flag [*1] or
    $past(ring_trailing_edge_flag))
    else $error("ring flag set from pin during loopback");

endmodule : umb_uart_modem
`default_nettype wire

// ==== tb/umb_modem_model.sv ====
// Far-side modem model driving the DSR, RI and DCD status lines
`timescale 1ns/1ps
`default_nettype none
module umb_modem_model #(
  parameter int SKEW_NS = 13
) (
  input  wire logic       aclk,
  input  wire logic [2:0] want,
  output var  logic       dsr_pin,
  output var  logic       ri_pin,
  output var  logic       dcd_pin
);
  // Lines idle low until the bench asks for a level
  initial begin
    {dcd_pin, ri_pin, dsr_pin} = 3'b000;
  end

  // Levels change a fixed skew after the edge, so they never change on a sampling edge
  always @(posedge aclk) begin
    #(SKEW_NS) {dcd_pin, ri_pin, dsr_pin} = want;
  end
endmodule : umb_modem_model
`default_nettype wire

// ==== tb/uart_modem_status_baud_gen_test.sv ====
// Self-checking bench for the modem status and baud block
`timescale 1ns/1ps
`default_nettype none
module uart_modem_status_baud_gen_test
  import umb_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        dsr_pin, ri_pin, dcd_pin, dtr_n_pin, modem_irq;
  logic        serial_prescaled_clock, baud_tick;
  logic [2:0]  want = 3'b000;
  logic [31:0] n;
  int          n_fail = 0;
  int          checked = 0;
  int          cycles = 0;

  umb_uart_modem i_umb_uart_modem (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .dsr_pin, .ri_pin, .dcd_pin, .dtr_n_pin, .modem_irq,
    .serial_prescaled_clock, .baud_tick
  );

  umb_modem_model i_umb_modem_model (
    .aclk, .want, .dsr_pin, .ri_pin, .dcd_pin
  );

  // 20 MHz clock
  always #25 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard: a run far beyond the expected length is a failure
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    if (n_fail == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////////
  // Bus write: address and data offered together, each dropped when taken
  task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk("bresp", s_axi_bresp, er);
    s_axi_bready <= 1'b0;
  endtask : wr

  // Bus read: data and response taken at the edge that sees rvalid
  task automatic rd(input logic [31:0] a, input logic [1:0] er,
                    output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    chk("rresp", s_axi_rresp, er);
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rc(input string w, input logic [31:0] a, exp);
    logic [31:0] d;
    rd(a, UMB_RESP_OKAY, d);
    chk(w, d, exp);
  endtask : rc

  // Pin change, then sync plus flag delay and the model's skew
  task automatic pins(input logic [2:0] v);
    want <= v;
    repeat (6) @(posedge aclk);
  endtask : pins

  // Cycles between two successive ticks of one generator output
  task automatic gap(input bit b);
    n = 0;
    do @(posedge aclk);
    while ((b ? baud_tick : serial_prescaled_clock) !== 1'b1);
    do begin
      @(posedge aclk);
      n++;
    end while ((b ? baud_tick : serial_prescaled_clock) !== 1'b1);
  endtask : gap

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rc("msr", UMB_OFF_MSR, 32'h0000_0000);
    rc("scratch", UMB_OFF_SCRATCH, 32'h0000_0000);
    rc("iid", UMB_OFF_IID, 32'(UMB_IID_NONE));
    chk("irq", modem_irq, 1'b0);
  endtask : t_reset

  task automatic t_scratch;
    wr(UMB_OFF_SCRATCH, 32'h0000_00a5, UMB_RESP_OKAY);
    rc("scratch", UMB_OFF_SCRATCH, 32'h0000_00a5);
    // Low byte lane disabled: the write is answered but stores nothing
    s_axi_wstrb <= 4'h0;
    wr(UMB_OFF_SCRATCH, 32'h0000_005a, UMB_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rc("no strobe", UMB_OFF_SCRATCH, 32'h0000_00a5);
    wr(UMB_OFF_MSR, 32'h0000_00ff, UMB_RESP_SLVERR);
    rd(32'h1d00_0340, UMB_RESP_SLVERR, n);
  endtask : t_scratch

  // Each line raised and dropped; ring flags only its rising edge
  task automatic t_edges;
    pins(3'b001);
    rc("dsr up", UMB_OFF_MSR, 32'h0000_0022);
    rc("cleared", UMB_OFF_MSR, 32'h0000_0020);
    pins(3'b000);
    rc("dsr down", UMB_OFF_MSR, 32'h0000_0002);
    pins(3'b010);
    rc("ri up", UMB_OFF_MSR, 32'h0000_0044);
    pins(3'b000);
    rc("ri down", UMB_OFF_MSR, 32'h0000_0000);
    pins(3'b100);
    rc("dcd up", UMB_OFF_MSR, 32'h0000_0088);
    pins(3'b000);
    rc("dcd down", UMB_OFF_MSR, 32'h0000_0008);
  endtask : t_edges

  task automatic t_irq;
    wr(UMB_OFF_IER, 32'h0000_0008, UMB_RESP_OKAY);
    rc("ier", UMB_OFF_IER, 32'h0000_0008);
    pins(3'b001);
    chk("irq on", modem_irq, 1'b1);
    rc("iid", UMB_OFF_IID, 32'(UMB_IID_MODEM));
    rc("msr", UMB_OFF_MSR, 32'h0000_0022);
    chk("irq off", modem_irq, 1'b0);
    wr(UMB_OFF_IER, 32'h0000_0000, UMB_RESP_OKAY);
    pins(3'b000);
    chk("irq masked", modem_irq, 1'b0);
    rc("msr", UMB_OFF_MSR, 32'h0000_0002);
  endtask : t_irq

  // Loopback: pins ignored, DSR follows the DTR control bit
  task automatic t_loop;
    wr(UMB_OFF_MCR, 32'h0000_0010, UMB_RESP_OKAY);
    rc("loop", UMB_OFF_MSR, 32'h0000_0000);
    wr(UMB_OFF_MCR, 32'h0000_0011, UMB_RESP_OKAY);
    rc("loop dsr", UMB_OFF_MSR, 32'h0000_0022);
    chk("dtr idle", dtr_n_pin, 1'b1);
    pins(3'b111);
    rc("pins cut", UMB_OFF_MSR, 32'h0000_0020);
    pins(3'b000);
    wr(UMB_OFF_MCR, 32'h0000_0000, UMB_RESP_OKAY);
    rc("leave", UMB_OFF_MSR, 32'h0000_0002);
  endtask : t_loop

  // Divisor bytes behind the select bit, then tick spacing
  task automatic t_baud;
    wr(UMB_OFF_LCR, 32'h0000_0080, UMB_RESP_OKAY);
    wr(UMB_OFF_DATA, 32'h0000_0003, UMB_RESP_OKAY);
    wr(UMB_OFF_IER, 32'h0000_005a, UMB_RESP_OKAY);
    rc("div low", UMB_OFF_DATA, 32'h0000_0003);
    rc("div high", UMB_OFF_IER, 32'h0000_005a);
    wr(UMB_OFF_IER, 32'h0000_0000, UMB_RESP_OKAY);
    wr(UMB_OFF_LCR, 32'h0000_0000, UMB_RESP_OKAY);
    rc("data", UMB_OFF_DATA, 32'h0000_0000);
    wr(UMB_OFF_PSC, 32'h0000_0003, UMB_RESP_OKAY);
    rc("psc", UMB_OFF_PSC, 32'h0000_0003);
    gap(1'b0);
    chk("psc gap", n, 32'd4);
    gap(1'b1);
    chk("baud gap", n, 32'd12);
    wr(UMB_OFF_LCR, 32'h0000_0080, UMB_RESP_OKAY);
    wr(UMB_OFF_DATA, 32'h0000_0001, UMB_RESP_OKAY);
    gap(1'b1);
    chk("baud div1", n, 32'd4);
  endtask : t_baud

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_scratch();
    t_edges();
    t_irq();
    t_loop();
    t_baud();
    end_of_test();
  end
endmodule : uart_modem_status_baud_gen_test
`default_nettype wire
